// ### design/tap_regs.vh
// tap_regs.vh: instruction codes, capture pattern and id fields of the test port
// assumes: included by the test port design files only
`ifndef TAP_REGS_VH
`define TAP_REGS_VH
`define IR_WIDTH          4
`define IR_CAPTURE        4'h1
`define INS_EXTEST        4'h0
`define INS_SAMPLE        4'h1
`define INS_IDCODE        4'h2
`define INS_CLAMP         4'h3
`define INS_HIGHZ         4'h4
`define INS_OFFSET_READ   4'h7
`define INS_THRESH_WRITE  4'h8
`define INS_BYPASS        4'hf
`define ID_WIDTH          32
`define ID_VERSION_LSB    28
`define ID_PART_LSB       12
`define ID_MFR_LSB        1
`define RESET_TMS_EDGES   5
`endif

// ### design/tap_shift_reg.v
// tap_shift_reg.v: generic capture/shift data register of the test port
// assumes: capture and shift are one-cycle strobes on a rising test-clock edge
`include "tap_regs.vh"
module tap_shift_reg #(
  parameter WIDTH = 32
) (
  // clock
  input  wire             clk,
  input  wire             rst_n,
  input  wire             ce,
  // control
  input  wire             capture,
  input  wire             shift,
  input  wire [WIDTH-1:0] cap_data,
  input  wire             sin,
  // result
  output wire             sout,
  output wire [WIDTH-1:0] value
);
  reg  [WIDTH-1:0] sr_r;
  // one spare bit on top keeps the shift a plain part-select even at width one
  wire [WIDTH:0]   sh_w = {sin, sr_r};

  always @(posedge clk) begin
    if (!rst_n) begin
      sr_r <= {WIDTH{1'b0}};
    end else if (ce) begin
      if (capture) begin
        sr_r <= cap_data;
      end else if (shift) begin
        sr_r <= sh_w[WIDTH:1];
      end
    end
  end

  assign sout  = sr_r[0];
  assign value = sr_r;
endmodule

// ### design/tap_controller.v
// tap_controller.v: boundary-scan test access port, state machine and scan paths
// assumes: test pins are asynchronous to clk; clk is far faster than the test clock
`include "tap_regs.vh"
module tap_controller #(
  parameter [3:0]  ID_VERSION = 4'h0,    // arbitrary value
  parameter [15:0] ID_PART    = 16'h0001, // arbitrary value
  parameter [10:0] ID_MFR     = 11'h001, // arbitrary value
  parameter        OFS_WIDTH  = 32
) (
  // system clock
  input  wire                 clk,
  input  wire                 rst_n,
  input  wire                 ce,
  // test pins
  input  wire                 tclk,
  input  wire                 tms,
  input  wire                 tdi,
  input  wire                 trst_n,
  output reg                  tdo,
  output reg                  tdo_oe,
  // device side
  input  wire [OFS_WIDTH-1:0] offset_rd_data,
  output reg  [OFS_WIDTH-1:0] offset_wr_data,
  output reg                  offset_wr_stb,
  output reg                  test_active,
  output reg                  outputs_clamp,
  output reg                  outputs_highz,
  output reg                  tap_ready
);
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [15:0] S_TLR = 16'h0001, S_RTI = 16'h0002, S_SDR = 16'h0004,
                    S_CDR = 16'h0008, S_SHD = 16'h0010, S_E1D = 16'h0020,
                    S_PDR = 16'h0040, S_E2D = 16'h0080, S_UDR = 16'h0100,
                    S_SIR = 16'h0200, S_CIR = 16'h0400, S_SHI = 16'h0800,
                    S_E1I = 16'h1000, S_PIR = 16'h2000, S_E2I = 16'h4000,
                    S_UIR = 16'h8000;

  // ----------------------------------------------------------------
  // pin synchronisers and test clock edges
  // ----------------------------------------------------------------
  reg [1:0] tclk_s_r, tms_s_r, tdi_s_r, trst_s_r;
  reg       tclk_d_r;
  always @(posedge clk) begin
    if (!rst_n) begin
      tclk_s_r <= 2'h0;
      tms_s_r  <= 2'h3;
      tdi_s_r  <= 2'h0;
      // idle high: releasing rst_n must not look like a test reset
      trst_s_r <= 2'h3;
      tclk_d_r <= 1'b0;
    end else if (ce) begin
      tclk_s_r <= {tclk_s_r[0], tclk};
      tms_s_r  <= {tms_s_r[0], tms};
      tdi_s_r  <= {tdi_s_r[0], tdi};
      trst_s_r <= {trst_s_r[0], trst_n};
      tclk_d_r <= tclk_s_r[1];
    end
  end
  wire t_rise = tclk_s_r[1] & ~tclk_d_r;
  wire t_fall = ~tclk_s_r[1] & tclk_d_r;
  wire tms_q  = tms_s_r[1];
  wire tdi_q  = tdi_s_r[1];
  wire trst_a = ~trst_s_r[1];

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  // the state register is not cleared by rst_n: only the test reset or the
  // mode-high sequence brings it to a defined state
  reg [15:0] state_r;
  reg [15:0] state_nxt;
  reg        known_r;

  always @* begin
    case (state_r)
      S_TLR:   state_nxt = tms_q ? S_TLR : S_RTI;
      S_RTI:   state_nxt = tms_q ? S_SDR : S_RTI;
      S_SDR:   state_nxt = tms_q ? S_SIR : S_CDR;
      S_CDR:   state_nxt = tms_q ? S_E1D : S_SHD;
      S_SHD:   state_nxt = tms_q ? S_E1D : S_SHD;
      S_E1D:   state_nxt = tms_q ? S_UDR : S_PDR;
      S_PDR:   state_nxt = tms_q ? S_E2D : S_PDR;
      S_E2D:   state_nxt = tms_q ? S_UDR : S_SHD;
      S_UDR:   state_nxt = tms_q ? S_SDR : S_RTI;
      S_SIR:   state_nxt = tms_q ? S_TLR : S_CIR;
      S_CIR:   state_nxt = tms_q ? S_E1I : S_SHI;
      S_SHI:   state_nxt = tms_q ? S_E1I : S_SHI;
      S_E1I:   state_nxt = tms_q ? S_UIR : S_PIR;
      S_PIR:   state_nxt = tms_q ? S_E2I : S_PIR;
      S_E2I:   state_nxt = tms_q ? S_UIR : S_SHI;
      S_UIR:   state_nxt = tms_q ? S_SDR : S_RTI;
      default: state_nxt = tms_q ? S_TLR : S_RTI;
    endcase
  end

  // tms-high edge counter forces reset from any state, even undefined
  reg  [2:0] ones_r;
  wire       five_ones = t_rise & tms_q & (ones_r >= 3'h4);
  always @(posedge clk) begin
    if (ce) begin
      if (trst_a || five_ones) begin
        state_r <= S_TLR;
      end else if (t_rise) begin
        state_r <= state_nxt;
      end
    end
  end
  // the counter and the reset-seen flag are helpers, not test state: rst_n
  // clears them so that the mode-high sequence works right after power-up
  always @(posedge clk) begin
    if (!rst_n) begin
      ones_r  <= 3'h0;
      known_r <= 1'b0;
    end else if (ce) begin
      if (trst_a) begin
        ones_r  <= 3'h0;
        known_r <= 1'b1;
      end else if (t_rise) begin
        ones_r <= tms_q ? ((ones_r == 3'h7) ? ones_r : ones_r + 3'h1) : 3'h0;
        if (five_ones) begin
          known_r <= 1'b1;
        end
      end
    end
  end
  // the unknown state is reported until a reset has happened
  wire in_tlr = known_r & (state_r == S_TLR);

  // ----------------------------------------------------------------
  // instruction path
  // ----------------------------------------------------------------
  wire [3:0] ir_sr;
  wire       ir_sout;
  reg  [3:0] ir_cur_r;
  tap_shift_reg #(.WIDTH(`IR_WIDTH)) u_ir (
    .clk      (clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .capture  (t_rise & (state_r == S_CIR)),
    .shift    (t_rise & (state_r == S_SHI)),
    .cap_data (`IR_CAPTURE),
    .sin      (tdi_q),
    .sout     (ir_sout),
    .value    (ir_sr)
  );

  always @(posedge clk) begin
    if (!rst_n) begin
      ir_cur_r <= `INS_IDCODE;
    end else if (ce) begin
      if (trst_a || (t_rise && in_tlr)) begin
        ir_cur_r <= `INS_IDCODE;
      end else if (t_fall && state_r == S_UIR) begin
        ir_cur_r <= ir_sr;
      end
    end
  end

  // ----------------------------------------------------------------
  // data registers
  // ----------------------------------------------------------------
  wire sel_id  = (ir_cur_r == `INS_IDCODE);
  wire sel_ofr = (ir_cur_r == `INS_OFFSET_READ);
  wire sel_ofw = (ir_cur_r == `INS_THRESH_WRITE);
  wire sel_bsr = (ir_cur_r == `INS_EXTEST) | (ir_cur_r == `INS_SAMPLE);
  // boundary cells are not modelled; their codes use the single stage too
  wire sel_byp = ~(sel_id | sel_ofr | sel_ofw);
  wire cap_dr  = t_rise & (state_r == S_CDR);
  wire sh_dr   = t_rise & (state_r == S_SHD);

  wire [31:0] id_word = {ID_VERSION, ID_PART, ID_MFR, 1'b1};
  wire id_sout, byp_sout, ofs_sout;
  wire [OFS_WIDTH-1:0] ofs_val;

  tap_shift_reg #(.WIDTH(`ID_WIDTH)) u_id (
    .clk(clk), .rst_n(rst_n), .ce(ce),
    .capture(cap_dr & sel_id), .shift(sh_dr & sel_id),
    .cap_data(id_word), .sin(tdi_q), .sout(id_sout), .value()
  );
  tap_shift_reg #(.WIDTH(1)) u_single_stage_pass_register (
    .clk(clk), .rst_n(rst_n), .ce(ce),
    .capture(cap_dr & (sel_byp | sel_bsr)), .shift(sh_dr & (sel_byp | sel_bsr)),
    .cap_data(1'b0), .sin(tdi_q), .sout(byp_sout), .value()
  );
  tap_shift_reg #(.WIDTH(OFS_WIDTH)) u_ofs (
    .clk(clk), .rst_n(rst_n), .ce(ce),
    .capture(cap_dr & (sel_ofr | sel_ofw)), .shift(sh_dr & (sel_ofr | sel_ofw)),
    .cap_data(offset_rd_data), .sin(tdi_q), .sout(ofs_sout), .value(ofs_val)
  );

  // ----------------------------------------------------------------
  // outputs; tdo changes on the falling test edge
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
      offset_wr_data <= {OFS_WIDTH{1'b0}};
      offset_wr_stb <= 1'b0;
      test_active <= 1'b0;
      outputs_clamp <= 1'b0;
      outputs_highz <= 1'b0;
      tap_ready <= 1'b0;
    end else if (ce) begin
      offset_wr_stb <= 1'b0;
      tap_ready <= known_r;
      // test control only away from reset and for active codes
      test_active   <= known_r & ~in_tlr & (sel_bsr | sel_ofw | (ir_cur_r == `INS_CLAMP));
      outputs_clamp <= known_r & ~in_tlr & (ir_cur_r == `INS_CLAMP);
      outputs_highz <= known_r & ~in_tlr & (ir_cur_r == `INS_HIGHZ);
      if (t_fall && sel_ofw && state_r == S_UDR) begin
        offset_wr_data <= ofs_val; // relies on serial pins held off
        offset_wr_stb  <= 1'b1;
      end
      if (t_fall) begin
        tdo_oe <= (state_r == S_SHI) | (state_r == S_SHD);
        tdo    <= (state_r == S_SHI) ? ir_sout :
                  sel_id ? id_sout : (sel_ofr | sel_ofw) ? ofs_sout : byp_sout;
      end
    end
  end
endmodule

// ### test/tap_checker_monitor.sv
// tap_checker_monitor.sv: port assertions for the test port controller
// assumes: bound to tap_controller; clk rising edge, rst_n synchronous low
module tap_checker #(
  parameter OFS_WIDTH = 32
) (
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire logic                 trst_n,
  input wire logic                 tdo_oe,
  input wire logic [OFS_WIDTH-1:0] offset_wr_data,
  input wire logic                 offset_wr_stb,
  input wire logic                 test_active,
  input wire logic                 outputs_clamp,
  input wire logic                 outputs_highz,
  input wire logic                 tap_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_ready_hold; tap_ready |=> tap_ready; endproperty
  a_ready_hold: assert property (p_ready_hold)
    else $error("tap ready dropped");
  property p_ready_oe; !tap_ready |-> !tdo_oe; endproperty
  a_ready_oe: assert property (p_ready_oe)
    else $error("serial out driven before port reset");
  property p_trst_quiet;
    (!trst_n) [*6] |-> !test_active && !outputs_clamp && !outputs_highz;
  endproperty
  a_trst_quiet: assert property (p_trst_quiet)
    else $error("test logic active in reset state");
  property p_trst_oe; (!trst_n) [*6] |-> !tdo_oe; endproperty
  a_trst_oe: assert property (p_trst_oe)
    else $error("serial out driven during test reset");
  property p_stb_pulse; offset_wr_stb |=> !offset_wr_stb; endproperty
  a_stb_pulse: assert property (p_stb_pulse)
    else $error("write strobe longer than one cycle");
  property p_stb_active; offset_wr_stb |-> test_active; endproperty
  a_stb_active: assert property (p_stb_active)
    else $error("write strobe without active test logic");
  property p_modes; !(outputs_clamp && outputs_highz); endproperty
  a_modes: assert property (p_modes)
    else $error("clamp and high impedance together");
  property p_clamp_act; outputs_clamp |-> test_active; endproperty
  a_clamp_act: assert property (p_clamp_act)
    else $error("clamp without active test logic");
  property p_wr_data; $changed(offset_wr_data) |-> offset_wr_stb; endproperty
  a_wr_data: assert property (p_wr_data)
    else $error("write word changed without strobe");
  c_stb: cover property (offset_wr_stb);
  c_clamp: cover property ($rose(outputs_clamp));
  c_ready: cover property ($rose(tap_ready));
endmodule

bind tap_controller tap_checker #(.OFS_WIDTH(OFS_WIDTH)) tap_checker_inst (
  .clk(clk), .rst_n(rst_n), .trst_n(trst_n), .tdo_oe(tdo_oe),
  .offset_wr_data(offset_wr_data), .offset_wr_stb(offset_wr_stb),
  .test_active(test_active), .outputs_clamp(outputs_clamp),
  .outputs_highz(outputs_highz), .tap_ready(tap_ready));

// ### test/scan_tester.sv
// scan_tester.sv: behavioural tester driving the test pins
// assumes: 32 ns test clock, idle low between scans; scans start in idle
module scan_tester (
  // test pins
  output logic     tclk,
  output logic     tms,
  output logic     tdi,
  output logic     trst_n,
  input wire logic tdo
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    tclk = 0;
    tms = 1;
    tdi = 0;
    trst_n = 1;
  end
  // sample late in the high phase: serial out moves only after a falling edge
  task automatic tick(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #16 tclk = 1;
    #15 o = tdo;
    #1 tclk = 0;
  endtask
  // lsb first; p is the bit after which the shift pauses
  task automatic scan(input logic ir, input int n, input int p,
                      input logic [31:0] din, output logic [31:0] dout);
    logic b;
    dout = '0;
    tick(1, 0, b);
    if (ir) tick(1, 0, b);
    tick(0, 0, b);
    tick(0, 0, b);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1 || i == p, din[i], b);
      dout[i] = b;
      if (i == p) begin
        tick(0, 0, b);
        tick(0, 0, b);
        tick(1, 0, b);
        tick(0, 0, b);
      end
    end
    tick(1, 0, b);
    tick(0, 0, b);
  endtask
  task automatic treset;
    trst_n = 0;
    #40 trst_n = 1;
  endtask
endmodule

// ### test/boundary_scan_tap_controller_bench.sv
// boundary_scan_tap_controller_bench.sv: self-checking bench of the test port
// assumes: scan_tester drives the pins; checker bound separately
module boundary_scan_tap_controller_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] ID_EXP = {4'h0, 16'h0001, 11'h001, 1'b1};
  logic        clk = 0, rst_n = 0, ce = 1;
  logic        tclk, tms, tdi, trst_n, tdo, tdo_oe, stb, act, clamp, highz, ready, b;
  logic [31:0] rd = 0, wr, seen, got;
  int          n_mismatch, samples_checked, n_stb;
  logic [3:0]  codes [8] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9, 4'hf};
  tap_controller tap_controller_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .tclk(tclk),
    .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe),
    .offset_rd_data(rd), .offset_wr_data(wr), .offset_wr_stb(stb), .test_active(act),
    .outputs_clamp(clamp), .outputs_highz(highz), .tap_ready(ready));
  scan_tester scan_tester_inst (.tclk(tclk), .tms(tms), .tdi(tdi), .trst_n(trst_n),
    .tdo(tdo));
  initial forever #2 clk = ~clk;
  always @(posedge clk) if (stb === 1'b1) begin
    n_stb++;
    seen = wr;
  end
  task automatic chk(string what, logic [31:0] exp, logic [31:0] v);
    samples_checked++;
    if (v !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, v);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic ir(input logic [3:0] c);
    scan_tester_inst.scan(1, 4, 99, {28'h0, c}, got);
  endtask
  task automatic dr(input int n, input int p, input logic [31:0] d);
    scan_tester_inst.scan(0, n, p, d, got);
  endtask
  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_bring_up;
    // wait well past the pin synchronisers so a false test reset would show
    #32 chk("ready before port reset", 0, ready);
    repeat (5) scan_tester_inst.tick(1, 0, b);
    for (int k = 0; k < 20 && ready !== 1'b1; k++) @(posedge clk);
    if (ready !== 1'b1) begin
      n_mismatch++;
      final_report();
    end
    scan_tester_inst.tick(0, 0, b);
    chk("test logic after reset", 0, act);
    $display("done bring_up");
  endtask
  task automatic t_idcode;
    dr(32, 99, 32'hffffffff);
    chk("id word", ID_EXP, got);
    dr(32, 13, 32'h0);
    chk("id word with pause", ID_EXP, got);
    $display("done idcode");
  endtask
  task automatic t_codes;
    foreach (codes[i]) begin
      ir(codes[i]);
      chk("ir capture", 32'h1, got);
      dr(2, 99, 32'h1);
      chk("bypass path", 32'h2, got);
      chk("clamp", codes[i] == 4'h3, clamp);
      chk("highz", codes[i] == 4'h4, highz);
      chk("active", codes[i] <= 4'h1 || codes[i] == 4'h3, act);
    end
    $display("done codes");
  endtask
  task automatic t_offset;
    // keep the tester's phase: its tdo sample must stay clear of the clk edge
    rd = 32'h5a3c0f81;
    ir(4'h7);
    dr(32, 99, 32'h0);
    chk("offset read", 32'h5a3c0f81, got);
    ir(4'h8);
    n_stb = 0;
    // no serial offset pins are driven by the tester during the test write
    dr(32, 99, 32'hc3a51e69);
    chk("strobe count", 1, n_stb);
    chk("offset write", 32'hc3a51e69, seen);
    chk("active in write", 1, act);
    repeat (3) scan_tester_inst.tick(1, 0, b);
    #20 chk("active after select exit", 0, act);
    scan_tester_inst.tick(0, 0, b);
    $display("done offset");
  endtask
  task automatic t_trst;
    ir(4'h3);
    chk("clamp on", 1, clamp);
    scan_tester_inst.treset();
    #8 chk("clamp after test reset", 0, clamp);
    scan_tester_inst.tick(0, 0, b);
    dr(32, 99, 32'h0);
    chk("id after test reset", ID_EXP, got);
    $display("done trst");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1 rst_n = 1;
    #1.3;
    t_bring_up();
    t_idcode();
    t_codes();
    t_offset();
    t_trst();
    final_report();
  end
endmodule
